// *** include/ulms_pkg.sv ***
// Constants shared by the line and peer signal status block
package ulms_pkg;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int ADDR_W     = 3;
    localparam int DATA_W     = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W      = 5;
    localparam int CNT_W      = 6;
    localparam int MDM_N      = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_RX_DATA  = 3'h0;
    localparam logic [ADDR_W-1:0] REG_LINE     = 3'h1;
    localparam logic [ADDR_W-1:0] REG_PEER     = 3'h2;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 3'h3;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 3'h4;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 3'h5;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LINE_AVAIL    = 0;
    localparam int LINE_OVERFLOW = 1;
    localparam int LINE_PARITY   = 2;
    localparam int LINE_STOP     = 3;
    localparam int LINE_SUMMARY  = 7;
    localparam int CTRL_FIFO_EN  = 0;
    localparam int CTRL_FLUSH    = 1;
    localparam int INT_RX_AVAIL  = 0;
    localparam int INT_OVERFLOW  = 1;
    localparam int INT_LINE_ERR  = 2;
    localparam int INT_PEER      = 3;
    localparam int INT_N         = 4;
    localparam int PEER_LEVEL_LO = 4;
    localparam int MDM_CTS       = 0;
    localparam int MDM_DSR       = 1;
    localparam int MDM_RI        = 2;
    localparam int MDM_DCD       = 3;
    localparam int ENTRY_PARITY  = 8;
    localparam int ENTRY_STOP    = 9;
    localparam int ENTRY_BREAK   = 10;
    localparam int ENTRY_W       = 11;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] CTRL_RESET     = 8'h00;
    localparam logic [DATA_W-1:0] INT_MASK_RESET = 8'h00;
    localparam logic [MDM_N-1:0]  PIN_IDLE       = 4'hF;
endpackage : ulms_pkg

// *** logic/ulms_sync2.sv ***
// Two-stage synchroniser for a group of asynchronous input pins
module ulms_sync2 #(
    parameter int                 WIDTH = 1,
    parameter logic [WIDTH-1:0]   INIT  = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ulms_sync_t;

    ulms_sync_t state;
    ulms_sync_t next_state;

    always_comb begin
        next_state.meta   = pin_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= {INIT, INIT};
        end else begin
            state <= next_state;
        end
    end

    assign pin_sync = state.stable;
endmodule : ulms_sync2

// *** logic/ulms_rx_fifo.sv ***
// Receive character queue holding data with its error flags
module ulms_rx_fifo
    import ulms_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               flush,
    input  wire logic               push,
    input  wire logic [ENTRY_W-1:0] push_entry,
    input  wire logic               pop,
    output logic      [ENTRY_W-1:0] head_entry,
    output logic      [CNT_W-1:0]   count
);
    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
    } ulms_fifo_t;

    ulms_fifo_t         state;
    ulms_fifo_t         next_state;
    logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
    logic               do_push;
    logic               do_pop;

    // Caller never pushes when full nor pops when empty
    assign do_push = push && !flush;
    assign do_pop  = pop && !flush && (state.count != '0);

    always_comb begin
        next_state = state;
        if (flush) begin
            next_state = '0;
        end else begin
            if (do_push) begin
                next_state.wr_ptr = state.wr_ptr + 5'h1;
            end
            if (do_pop) begin
                next_state.rd_ptr = state.rd_ptr + 5'h1;
            end
            if (do_push && !do_pop) begin
                next_state.count = state.count + 6'h01;
            end else if (do_pop && !do_push) begin
                next_state.count = state.count - 6'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[state.wr_ptr] <= push_entry;
        end
    end

    assign head_entry = mem[state.rd_ptr];
    assign count      = state.count;
endmodule : ulms_rx_fifo

// *** logic/ulms_status.sv ***
// Receive line condition, peer signal state and interrupt logic
//
// Implementation choices: the register addresses and the plain strobed port.
module ulms_status
    import ulms_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              rx_char_done,
    input  wire logic [DATA_W-1:0] rx_char_data,
    input  wire logic              rx_char_parity_bad,
    input  wire logic              rx_char_stop_bad,
    input  wire logic              rx_char_break,
    input  wire logic              cts_n,
    input  wire logic              dsr_n,
    input  wire logic              ri_n,
    input  wire logic              dcd_n,
    output logic                   rx_char_available,
    output logic                   peer_irq_request,
    output logic                   irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [DATA_W-1:0] ctrl;
        logic [DATA_W-1:0] int_mask;
        logic [INT_N-1:0]  int_stat;
        logic              overflow;
        logic              summary;
        logic [CNT_W-1:0]  err_count;
        logic [MDM_N-1:0]  mdm_prev;
        logic [MDM_N-1:0]  mdm_delta;
    } ulms_state_t;

    ulms_state_t        state;
    ulms_state_t        next_state;

    logic [MDM_N-1:0]   pins_sync;
    logic [MDM_N-1:0]   mdm_level;
    logic [ENTRY_W-1:0] head_entry;
    logic [CNT_W-1:0]   fifo_count;
    logic [ENTRY_W-1:0] push_entry;
    logic [CNT_W-1:0]   capacity;
    logic               fifo_full;
    logic               fifo_empty;
    logic               push;
    logic               pop;
    logic               flush;
    logic               push_err;
    logic               pop_err;
    logic               head_parity;
    logic               head_stop;
    logic [DATA_W-1:0]  line_value;
    logic [DATA_W-1:0]  peer_value;
    logic               rd_line;
    logic               rd_peer;
    logic               rd_int;
    logic               rd_data;
    logic               wr_ctrl;
    logic               wr_mask;
    logic               rd_ctrl;
    logic               rd_mask;
    logic               rx_drop;
    logic [MDM_N-1:0]   mdm_change;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ulms_sync2 #(
        .WIDTH (MDM_N),
        .INIT  (PIN_IDLE)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .pin_in   ({dcd_n, ri_n, dsr_n, cts_n}),
        .pin_sync (pins_sync)
    );

    // Pins are active low; register shows asserted as one
    assign mdm_level = ~pins_sync;

    // ------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------
    ulms_rx_fifo u_rx_fifo (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .flush      (flush),
        .push       (push),
        .push_entry (push_entry),
        .pop        (pop),
        .head_entry (head_entry),
        .count      (fifo_count)
    );

    // Without queue mode only a single holding slot is used
    assign capacity   = state.ctrl[CTRL_FIFO_EN] ? CNT_W'(FIFO_DEPTH) : 6'h01;
    assign fifo_full  = (fifo_count >= capacity);
    assign fifo_empty = (fifo_count == '0);

    assign push_entry = {rx_char_break, rx_char_stop_bad, rx_char_parity_bad, rx_char_data};
    assign push       = rx_char_done && !fifo_full && !flush;
    assign rx_drop    = rx_char_done && fifo_full && !flush;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    always_comb begin
        rd_line = 1'b0;
        rd_peer = 1'b0;
        rd_int  = 1'b0;
        rd_data = 1'b0;
        wr_ctrl = 1'b0;
        wr_mask = 1'b0;
        rd_ctrl = 1'b0;
        rd_mask = 1'b0;
        if (reg_read && reg_addr == REG_LINE) begin
            rd_line = 1'b1;
        end else if (reg_read && reg_addr == REG_PEER) begin
            rd_peer = 1'b1;
        end else if (reg_read && reg_addr == REG_INT_STAT) begin
            rd_int = 1'b1;
        end else if (reg_read && reg_addr == REG_RX_DATA) begin
            rd_data = 1'b1;
        end else if (reg_read && reg_addr == REG_CTRL) begin
            rd_ctrl = 1'b1;
        end else if (reg_read && reg_addr == REG_INT_MASK) begin
            rd_mask = 1'b1;
        end else if (reg_write && reg_addr == REG_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (reg_write && reg_addr == REG_INT_MASK) begin
            wr_mask = 1'b1;
        end
    end

    assign pop   = rd_data && !fifo_empty;
    // Changing queue mode or the flush bit empties the queue
    assign flush = wr_ctrl && (reg_wdata[CTRL_FLUSH]
                   || (reg_wdata[CTRL_FIFO_EN] != state.ctrl[CTRL_FIFO_EN]));

    assign push_err = push && (rx_char_parity_bad || rx_char_stop_bad || rx_char_break);
    assign pop_err  = pop && (head_entry[ENTRY_PARITY] || head_entry[ENTRY_STOP]
                      || head_entry[ENTRY_BREAK]);

    // ------------------------------------------------------------
    // Read values
    // ------------------------------------------------------------
    // head stop bit fault
    assign head_stop   = !fifo_empty && head_entry[ENTRY_STOP];
    assign head_parity = !fifo_empty && head_entry[ENTRY_PARITY];

    always_comb begin
        line_value                = '0;
        line_value[LINE_AVAIL]    = !fifo_empty;
        line_value[LINE_OVERFLOW] = state.overflow;
        line_value[LINE_PARITY]   = head_parity;
        line_value[LINE_STOP]     = head_stop;
        line_value[LINE_SUMMARY]  = state.summary;
    end

    assign peer_value = {mdm_level, state.mdm_delta};

    assign mdm_change = mdm_level ^ state.mdm_prev;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;

        // --------------------------------------------------------
        // Read data
        // --------------------------------------------------------
        next_state.rdata = '0;
        if (rd_line) begin
            next_state.rdata = line_value;
        end else if (rd_peer) begin
            next_state.rdata = peer_value;
        end else if (rd_int) begin
            next_state.rdata = {{(DATA_W-INT_N){1'b0}}, state.int_stat};
        end else if (rd_data && !fifo_empty) begin
            next_state.rdata = head_entry[DATA_W-1:0];
        end else if (rd_ctrl) begin
            next_state.rdata = state.ctrl;
        end else if (rd_mask) begin
            next_state.rdata = state.int_mask;
        end

        if (wr_ctrl) begin
            next_state.ctrl               = '0;
            next_state.ctrl[CTRL_FIFO_EN] = reg_wdata[CTRL_FIFO_EN];
        end
        if (wr_mask) begin
            next_state.int_mask = reg_wdata;
        end

        // --------------------------------------------------------
        // Line condition flags
        // --------------------------------------------------------
        // overflow, set wins
        if (rd_line) begin
            next_state.overflow = 1'b0;
        end
        if (rx_drop) begin
            next_state.overflow = 1'b1;
        end

        // Count errored entries still held in the queue
        if (flush) begin
            next_state.err_count = '0;
        end else if (push_err && !pop_err) begin
            next_state.err_count = state.err_count + 6'h01;
        end else if (pop_err && !push_err) begin
            next_state.err_count = state.err_count - 6'h01;
        end

        // summary, set wins
        // Also drops once no errored entry is left
        if (rd_line || flush || next_state.err_count == '0) begin
            next_state.summary = 1'b0;
        end
        if (push_err && state.ctrl[CTRL_FIFO_EN]) begin
            next_state.summary = 1'b1;
        end

        // --------------------------------------------------------
        // Peer change bits
        // --------------------------------------------------------
        // change detection
        next_state.mdm_prev = mdm_level;
        if (rd_peer) begin
            next_state.mdm_delta = '0;
        end
        next_state.mdm_delta = next_state.mdm_delta | mdm_change;

        // --------------------------------------------------------
        // Interrupt events
        // --------------------------------------------------------
        // Sticky interrupt events, cleared by reading them
        if (rd_int) begin
            next_state.int_stat = '0;
        end
        if (push) begin
            next_state.int_stat[INT_RX_AVAIL] = 1'b1;
        end
        if (rx_drop) begin
            next_state.int_stat[INT_OVERFLOW] = 1'b1;
        end
        if (push_err) begin
            next_state.int_stat[INT_LINE_ERR] = 1'b1;
        end
        if (mdm_change != '0) begin
            next_state.int_stat[INT_PEER] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state           <= '0;
            state.ctrl      <= CTRL_RESET;
            state.int_mask  <= INT_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata         = state.rdata;
    assign rx_char_available = !fifo_empty;
    assign peer_irq_request  = (state.mdm_delta != '0);
    assign irq               = ((state.int_stat & state.int_mask[INT_N-1:0]) != '0);
endmodule : ulms_status

// *** test/ulms_status_props.sv ***
// Port checker for the line and peer status block
module ulms_status_props
    import ulms_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              rx_char_done,
    input wire logic [DATA_W-1:0] rx_char_data,
    input wire logic              rx_char_parity_bad,
    input wire logic              rx_char_stop_bad,
    input wire logic              rx_char_break,
    input wire logic              cts_n,
    input wire logic              dsr_n,
    input wire logic              ri_n,
    input wire logic              dcd_n,
    input wire logic              rx_char_available,
    input wire logic              peer_irq_request,
    input wire logic              irq
);
    // ------------------------------------------------------------
    // Pin quiet counter and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [3:0] pins_n;
    logic [3:0] pins_q;
    logic [2:0] quiet;
    logic       rd_peer;
    assign pins_n  = {dcd_n, ri_n, dsr_n, cts_n};
    assign rd_peer = reg_read && reg_addr == REG_PEER;
    // Edges since the pins last moved
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pins_q <= 4'hF;
            quiet  <= 3'h0;
        end else begin
            pins_q <= pins_n;
            if (pins_n != pins_q) quiet <= 3'h0;
            else if (quiet != 3'h7) quiet <= quiet + 3'h1;
        end
    end
    property p_avail_push;
        rx_char_done && !rx_char_available && !reg_write |=> rx_char_available;
    endproperty
    a_avail_push: assert property (p_avail_push) else $error("no data after push");
    property p_avail_stays;
        rx_char_available && !reg_write && !(reg_read && reg_addr == REG_RX_DATA)
            |=> rx_char_available;
    endproperty
    a_avail_stays: assert property (p_avail_stays) else $error("data lost");
    property p_line_avail;
        reg_read && reg_addr == REG_LINE |=> reg_rdata[LINE_AVAIL] == $past(rx_char_available);
    endproperty
    a_line_avail: assert property (p_line_avail) else $error("line bit0 wrong");
    property p_peer_set;
        $changed(pins_n) |-> ##[1:5] peer_irq_request;
    endproperty
    a_peer_set: assert property (p_peer_set) else $error("pin change missed");
    property p_peer_stays;
        peer_irq_request && !rd_peer |=> peer_irq_request;
    endproperty
    a_peer_stays: assert property (p_peer_stays) else $error("change bit lost");
    property p_peer_clear;
        rd_peer && quiet >= 3'h5 |=> !peer_irq_request;
    endproperty
    a_peer_clear: assert property (p_peer_clear) else $error("change not cleared");
    property p_peer_level;
        rd_peer && quiet >= 3'h5 |=> reg_rdata[7:4] == ~$past(pins_n);
    endproperty
    a_peer_level: assert property (p_peer_level) else $error("pin levels wrong");
    property p_peer_bits;
        rd_peer |=> (|reg_rdata[3:0]) == $past(peer_irq_request);
    endproperty
    a_peer_bits: assert property (p_peer_bits) else $error("change bits wrong");
    c_overflow: cover property (reg_read && reg_addr == REG_LINE ##1 reg_rdata[LINE_OVERFLOW]);
    c_peer: cover property ($rose(peer_irq_request));
    c_irq: cover property ($rose(irq));
endmodule : ulms_status_props

bind ulms_status ulms_status_props u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
    .rx_char_parity_bad(rx_char_parity_bad), .rx_char_stop_bad(rx_char_stop_bad),
    .rx_char_break(rx_char_break), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
    .dcd_n(dcd_n), .rx_char_available(rx_char_available),
    .peer_irq_request(peer_irq_request), .irq(irq)
);

// *** test/ulms_peer_model.sv ***
// Far-end peer control line model
module ulms_peer_model (
    input  wire logic       slow,
    input  wire logic [3:0] asserted,
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ri_n,
    output logic            dcd_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Pins follow requests, late when slow
    // ------------------------------------------------------------
    initial {dcd_n, ri_n, dsr_n, cts_n} = 4'hF;
    always @(asserted) begin
        if (slow) #40;
        else #3;
        {dcd_n, ri_n, dsr_n, cts_n} = ~asserted;
    end
endmodule : ulms_peer_model

// *** test/tb_top.sv ***
// Self-checking bench for the line and peer status block
module tb_top
    import ulms_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Signals, design and peer
    // ------------------------------------------------------------
    logic              clk_sys      = 1'b0;
    logic              reset_n      = 1'b0;
    logic [ADDR_W-1:0] reg_addr     = 3'h0;
    logic [DATA_W-1:0] reg_wdata    = 8'h00;
    logic              reg_write    = 1'b0;
    logic              reg_read     = 1'b0;
    logic              rx_char_done = 1'b0;
    logic [DATA_W-1:0] rx_char_data = 8'h00;
    logic [2:0]        rx_flags     = 3'h0;
    logic              slow         = 1'b0;
    logic [3:0]        asserted     = 4'h0;
    logic [DATA_W-1:0] reg_rdata;
    logic              cts_n, dsr_n, ri_n, dcd_n;
    logic              rx_char_available, peer_irq_request, irq;
    int                mismatches   = 0;
    int                compares     = 0;
    always #12.5 clk_sys = ~clk_sys;
    ulms_status dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .rx_char_done(rx_char_done), .rx_char_data(rx_char_data),
        .rx_char_parity_bad(rx_flags[0]), .rx_char_stop_bad(rx_flags[1]),
        .rx_char_break(rx_flags[2]), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .dcd_n(dcd_n), .rx_char_available(rx_char_available),
        .peer_irq_request(peer_irq_request), .irq(irq)
    );
    ulms_peer_model peer (
        .slow(slow), .asserted(asserted), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
        .dcd_n(dcd_n)
    );
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdc
    task automatic push(input logic [DATA_W-1:0] d, input logic [2:0] f);
        @(posedge clk_sys);
        rx_char_done <= 1'b1;
        rx_char_data <= d;
        rx_flags     <= f;
        @(posedge clk_sys);
        rx_char_done <= 1'b0;
    endtask : push
    task automatic wait_peer();
        int n = 0;
        while (peer_irq_request !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(peer_irq_request, 1'b1);
        if (peer_irq_request !== 1'b1) end_of_test();
    endtask : wait_peer
    task automatic t_reset();
        rdc(REG_LINE, 8'h00);
        rdc(REG_PEER, 8'h00);
        rdc(REG_INT_MASK, 8'h00);
        rdc(3'h6, 8'h00);
        chk(rx_char_available, 1'b0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_single();
        push(8'h55, 3'h1);
        rdc(REG_LINE, 8'h05);
        rdc(REG_RX_DATA, 8'h55);
        rdc(REG_LINE, 8'h00);
        push(8'hA1, 3'h2);
        push(8'hA2, 3'h0);
        rdc(REG_LINE, 8'h0B);
        rdc(REG_LINE, 8'h09);
        rdc(REG_RX_DATA, 8'hA1);
        chk(rx_char_available, 1'b0);
        $display("test single slot done");
    endtask : t_single
    task automatic t_queue();
        wr(REG_CTRL, 8'h01);
        @(posedge clk_sys);
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            rx_char_done <= 1'b1;
            rx_char_data <= 8'(i);
            rx_flags     <= (i == 0) ? 3'h2 : (i == 1) ? 3'h1 : 3'h0;
            @(posedge clk_sys);
        end
        rx_char_done <= 1'b0;
        rdc(REG_LINE, 8'h8B);
        rdc(REG_LINE, 8'h09);
        rdc(REG_RX_DATA, 8'h00);
        rdc(REG_LINE, 8'h05);
        for (int i = 1; i < FIFO_DEPTH; i++) rdc(REG_RX_DATA, 8'(i));
        rdc(REG_LINE, 8'h00);
        $display("test queue done");
    endtask : t_queue
    task automatic t_peer();
        for (int i = 0; i < MDM_N; i++) begin
            @(posedge clk_sys);
            slow        <= i[0];
            asserted[i] <= 1'b1;
            wait_peer();
            rdc(REG_PEER, 8'((((1 << (i + 1)) - 1) << 4) | (1 << i)));
            rdc(REG_PEER, 8'(((1 << (i + 1)) - 1) << 4));
            chk(peer_irq_request, 1'b0);
        end
        @(posedge clk_sys);
        asserted <= 4'h0;
        wait_peer();
        rdc(REG_PEER, 8'h0F);
        $display("test peer done");
    endtask : t_peer
    task automatic t_irq();
        chk(irq, 1'b0);
        rdc(REG_INT_STAT, 8'h0F);
        wr(REG_INT_MASK, 8'h08);
        @(posedge clk_sys);
        asserted[MDM_RI] <= 1'b1;
        wait_peer();
        @(posedge clk_sys);
        #1 chk(irq, 1'b1);
        rdc(REG_PEER, 8'h44);
        chk(irq, 1'b1);
        rdc(REG_INT_STAT, 8'h08);
        chk(irq, 1'b0);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_flush();
        push(8'h3C, 3'h4);
        rdc(REG_LINE, 8'h81);
        push(8'h3E, 3'h1);
        rdc(REG_RX_DATA, 8'h3C);
        rdc(REG_RX_DATA, 8'h3E);
        rdc(REG_LINE, 8'h00);
        push(8'h3D, 3'h0);
        wr(REG_CTRL, 8'h03);
        rdc(REG_LINE, 8'h00);
        rdc(REG_CTRL, 8'h01);
        rdc(REG_RX_DATA, 8'h00);
        $display("test flush done");
    endtask : t_flush
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_single();
        t_queue();
        t_peer();
        t_irq();
        t_flush();
        end_of_test();
    end
endmodule : tb_top
